// ===== guard_timer_regs.svh
// Register map, field positions, reset values and timing counts of the guard timer.
`ifndef GUARD_TIMER_REGS_SVH
`define GUARD_TIMER_REGS_SVH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define GT_RCF_DATA_ADDR  8'h54
`define GT_IO_OFFSET      8'h20
`define GT_RCF_IO_ADDR    (`GT_RCF_DATA_ADDR - `GT_IO_OFFSET)
`define GT_CTRL_DATA_ADDR 8'h60

// ----------------------------------------------------------------
// Reset-cause flag positions
// ----------------------------------------------------------------
`define GT_RCF_POR   0
`define GT_RCF_PIN   1
`define GT_RCF_BROWN 2
`define GT_RCF_GUARD 3
`define GT_RCF_SCAN  4
`define GT_RCF_NUM   5
`define GT_RCF_RESET 8'h00

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define GT_C_FLAG 7
`define GT_C_IE   6
`define GT_C_P3   5
`define GT_C_CE   4
`define GT_C_RST_EN 3
`define GT_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GT_OSC_HZ         128000
`define GT_MIN_PERIOD_MS  16
`define GT_MAX_PERIOD_MS  8000
`define GT_BASE_CYCLES    (`GT_OSC_HZ * `GT_MIN_PERIOD_MS / 1000)
`define GT_MAX_CODE       4'h9
`define GT_UNLOCK_CYCLES  3'h4

`endif

// ===== guard_timer_pkg.sv
// Types shared by the guard timer design.
`default_nettype none

package guard_timer_pkg;

    // Action taken when the counter expires.
    typedef enum logic [1:0] {
        mode_stop,
        mode_irq,
        mode_rst,
        mode_both
    } mode_t;

endpackage : guard_timer_pkg

`default_nettype wire

// ===== guard_timer.sv
// Guard timer with unlock sequence and reset-cause flags.
`include "guard_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module guard_timer #(
    parameter int unsigned BASE_CYCLES = `GT_BASE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       osc_in,
    input  wire logic       io_sel,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wdata,
    input  wire logic       restart_req,
    input  wire logic       vector_ack,
    input  wire logic       always_on_fuse,
    input  wire logic       pin_rst_in,
    input  wire logic       brownout_rst_in,
    input  wire logic       scan_rst_in,
    output logic      [7:0] rdata,
    output logic            guard_reset,
    output logic            timeout_irq
);

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    logic       osc_s1_r;
    logic       osc_s2_r;
    logic       osc_s3_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic       tick;
    logic       fuse;
    logic       pin_rise;
    logic       brown_rise;
    logic       scan_rise;

    // The oscillator runs far slower than clk, so a three-stage chain
    // turns each of its rising edges into one clk-wide tick.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else if (clk_en) begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // Reset sources and the fuse arrive from outside this clock domain.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
        end else if (clk_en) begin
            pin_s1_r <= {always_on_fuse, scan_rst_in, brownout_rst_in, pin_rst_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    assign tick       = osc_s2_r & ~osc_s3_r;
    assign fuse       = pin_s2_r[3];
    assign pin_rise   = pin_s2_r[0] & ~pin_s3_r[0];
    assign brown_rise = pin_s2_r[1] & ~pin_s3_r[1];
    assign scan_rise  = pin_s2_r[2] & ~pin_s3_r[2];

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    logic rcf_hit;
    logic ctrl_hit;
    logic rcf_wr;
    logic ctrl_wr;

    // Flags answer in both spaces; control sits only in extended space.
    assign rcf_hit  = io_sel ? (addr == `GT_RCF_IO_ADDR)
                             : (addr == `GT_RCF_DATA_ADDR);
    assign ctrl_hit = !io_sel && (addr == `GT_CTRL_DATA_ADDR);
    assign rcf_wr   = wr_en && rcf_hit;
    assign ctrl_wr  = wr_en && ctrl_hit;

    // ----------------------------------------------------------------
    // Control state
    // ----------------------------------------------------------------
    logic       flag_r;
    logic       ie_r;
    logic       rst_en_r;
    logic [3:0] period_r;
    logic       chg_en_r;
    logic [2:0] chg_cnt_r;
    logic [`GT_RCF_NUM-1:0] rcf_r;
    logic       por_pend_r;
    logic       ie_eff;
    logic       rst_en_eff;
    logic       other_rst;
    logic       unlock_wr;
    guard_timer_pkg::mode_t mode;

    // The fuse overrides both enables; the guard reset flag holds the reset enable.
    assign ie_eff     = ie_r & ~fuse;
    assign rst_en_eff = rst_en_r | rcf_r[`GT_RCF_GUARD] | fuse;
    assign other_rst  = pin_rise | brown_rise | scan_rise;
    assign unlock_wr  = ctrl_wr && wdata[`GT_C_CE] && wdata[`GT_C_RST_EN];

    // Mode follows the configuration table; the fuse wins over software.
    always_comb begin
        if (fuse) begin
            mode = guard_timer_pkg::mode_rst;
        end else begin
            case ({rst_en_eff, ie_eff})
                2'b01:   mode = guard_timer_pkg::mode_irq;
                2'b10:   mode = guard_timer_pkg::mode_rst;
                2'b11:   mode = guard_timer_pkg::mode_both;
                default: mode = guard_timer_pkg::mode_stop;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic [20:0] cnt_r;
    logic [20:0] limit;
    logic [3:0]  code;
    logic        expire;
    logic        flag_set;
    logic        guard_fire;

    // Reserved codes fall back to the longest period rather than wrap.
    assign code  = (period_r > `GT_MAX_CODE) ? `GT_MAX_CODE : period_r;
    assign limit = 21'(BASE_CYCLES) << code;

    // Comparing with >= makes a switch to a shorter period expire at
    // once, which is why software should restart first.
    assign expire = tick && (mode != guard_timer_pkg::mode_stop)
                    && (cnt_r >= limit - 21'h00_0001);

    assign flag_set   = expire && ((mode == guard_timer_pkg::mode_irq)
                        || (mode == guard_timer_pkg::mode_both && !flag_r));
    assign guard_fire = expire && ((mode == guard_timer_pkg::mode_rst)
                        || (mode == guard_timer_pkg::mode_both && flag_r));

    // No sleep input exists: the counter runs whenever a mode is active.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 21'h00_0000;
        end else if (clk_en) begin
            if (restart_req || expire || guard_reset || other_rst) begin
                cnt_r <= 21'h00_0000;
            end else if (tick && mode != guard_timer_pkg::mode_stop) begin
                cnt_r <= cnt_r + 21'h00_0001;
            end
        end
    end

    // One-cycle system reset pulse on expiry in reset mode, or in combined mode with the flag already set.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guard_reset <= 1'b0;
        end else if (clk_en) begin
            guard_reset <= guard_fire;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flag and enable
    // ----------------------------------------------------------------
    // A new expiry beats a clear in the same cycle so no event is lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (clk_en) begin
            if (flag_set) begin
                flag_r <= 1'b1;
            end else if (guard_reset || other_rst) begin
                flag_r <= 1'b0;
            end else if (vector_ack || (ctrl_wr && wdata[`GT_C_FLAG])) begin
                flag_r <= 1'b0;
            end
        end
    end

    // Vector execution in combined mode drops the enable, leaving reset mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ie_r <= 1'b0;
        end else if (clk_en) begin
            if (guard_reset || other_rst) begin
                ie_r <= 1'b0;
            end else if (vector_ack && rst_en_eff) begin
                ie_r <= 1'b0;
            end else if (ctrl_wr) begin
                ie_r <= wdata[`GT_C_IE];
            end
        end
    end

    // Interrupt output; it follows the flag gated by the effective enable, one edge later.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timeout_irq <= 1'b0;
        end else if (clk_en) begin
            timeout_irq <= flag_r & ie_eff;
        end
    end

    // ----------------------------------------------------------------
    // Timed unlock
    // ----------------------------------------------------------------
    // The window opens the edge after the unlock write and lasts four
    // cycles; further writes inside it do not stretch it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chg_en_r  <= 1'b0;
            chg_cnt_r <= 3'h0;
        end else if (clk_en) begin
            if (guard_reset || other_rst) begin
                chg_en_r  <= 1'b0;
                chg_cnt_r <= 3'h0;
            end else if (chg_en_r) begin
                chg_cnt_r <= chg_cnt_r - 3'h1;
                if (chg_cnt_r == 3'h1) begin
                    chg_en_r <= 1'b0;
                end
            end else if (unlock_wr) begin
                chg_en_r  <= 1'b1;
                chg_cnt_r <= `GT_UNLOCK_CYCLES;
            end
        end
    end

    // The reset enable may always be set; clearing it or changing the period
    // needs the window. After a guard reset the enable comes back set.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_en_r <= 1'b0;
            period_r <= 4'h0;
        end else if (clk_en) begin
            if (guard_reset) begin
                rst_en_r <= 1'b1;
                period_r <= 4'h0;
            end else if (other_rst) begin
                rst_en_r <= 1'b0;
                period_r <= 4'h0;
            end else if (ctrl_wr && chg_en_r) begin
                rst_en_r <= wdata[`GT_C_RST_EN] | rcf_r[`GT_RCF_GUARD];
                period_r <= {wdata[`GT_C_P3], wdata[2:0]};
            end else if (ctrl_wr) begin
                rst_en_r <= rst_en_r | wdata[`GT_C_RST_EN];
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset-cause flags
    // ----------------------------------------------------------------
    localparam logic [7:0] RCF_RST = `GT_RCF_RESET;

    logic [`GT_RCF_NUM-1:0] rcf_set;

    // Power-on is the async reset; its flag is raised just after release.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            por_pend_r <= 1'b1;
        end else if (clk_en) begin
            por_pend_r <= 1'b0;
        end
    end

    assign rcf_set[`GT_RCF_POR]   = por_pend_r;
    assign rcf_set[`GT_RCF_PIN]   = pin_rise;
    assign rcf_set[`GT_RCF_BROWN] = brown_rise;
    assign rcf_set[`GT_RCF_GUARD] = guard_reset;
    assign rcf_set[`GT_RCF_SCAN]  = scan_rise;

    // Only power-on (async reset) or a written zero clears a flag; a set
    // in the same cycle as the write wins.
    for (genvar i = 0; i < `GT_RCF_NUM; i++) begin : g_rcf
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rcf_r[i] <= RCF_RST[i];
            end else if (clk_en) begin
                if (rcf_set[i]) begin
                    rcf_r[i] <= 1'b1;
                end else if (rcf_wr && !wdata[i]) begin
                    rcf_r[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Reads return data one edge after rd_en; unmapped addresses give zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (clk_en && rd_en) begin
            if (rcf_hit) begin
                rdata <= {3'b000, rcf_r};
            end else if (ctrl_hit) begin
                rdata <= {flag_r, ie_eff, period_r[3], chg_en_r,
                          rst_en_eff, period_r[2:0]};
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_CE_CLEAR: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        $rose(chg_en_r) |-> chg_en_r [*4] ##1 !chg_en_r)
        else $error("Change enable did not last exactly four cycles.");

    AST_RST_MODE: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (expire && mode == guard_timer_pkg::mode_rst) |=> guard_reset ##1 !guard_reset)
        else $error("Reset mode expiry did not give a one-cycle reset.");

    AST_IRQ_MODE: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (expire && mode == guard_timer_pkg::mode_irq) |=> flag_r && !guard_reset
        ##1 timeout_irq)
        else $error("Interrupt mode expiry did not raise the interrupt.");

    AST_BOTH_SEQ: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (expire && mode == guard_timer_pkg::mode_both) |=> (guard_reset == $past(flag_r)))
        else $error("Combined mode took the wrong action.");

    AST_FUSE: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (fuse && tick && cnt_r >= limit - 21'h00_0001) |=> guard_reset && !flag_r)
        else $error("Fuse did not force reset mode.");

    AST_RESTART: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        restart_req |=> cnt_r == 21'h00_0000)
        else $error("Restart did not clear the counter.");

    AST_LOCKED: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (ctrl_wr && !chg_en_r && !guard_reset && !other_rst) |=> $stable(period_r)
        && (rst_en_r || !$past(rst_en_r)))
        else $error("Locked write changed the period or cleared the reset enable.");

    AST_GUARD_FLAG: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        guard_reset |=> rcf_r[`GT_RCF_GUARD] && rst_en_eff)
        else $error("Guard reset did not set its flag.");

    AST_GUARD_HOLD: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (rcf_r[`GT_RCF_GUARD] && ctrl_wr && !other_rst) |=> rst_en_r)
        else $error("Reset enable cleared while guard reset flag set.");

    AST_READ_IO: assert property (@(posedge clk) disable iff (!nrst || !clk_en)
        (rd_en && io_sel && addr == `GT_RCF_IO_ADDR) |=> rdata == {3'b000, $past(rcf_r)})
        else $error("Flag read in I/O space returned wrong data.");

endmodule : guard_timer

`default_nettype wire

// ===== guard_timer_tb.sv
// Self-checking testbench for the guard timer register and expiry behaviour.
`timescale 1ns/1ps
`default_nettype none

module guard_timer_tb;

    // ----------------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------------
    localparam int unsigned BASE  = 4;
    localparam int          LIMIT = 40000;

    logic       clk;
    logic       nrst;
    logic       clk_en;
    logic       osc_in;
    logic       osc_run;
    logic       io_sel;
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
    logic       restart_req;
    logic       vector_ack;
    logic       fuse;
    logic [2:0] src;
    logic [7:0] rdata;
    logic       guard_reset;
    logic       timeout_irq;
    logic [7:0] rv;
    int         err_total;
    int         comparisons;
    int         cyc;

    guard_timer #(.BASE_CYCLES(BASE)) uut (
        .clk             (clk),
        .nrst            (nrst),
        .clk_en          (clk_en),
        .osc_in          (osc_in),
        .io_sel          (io_sel),
        .addr            (addr),
        .wr_en           (wr_en),
        .rd_en           (rd_en),
        .wdata           (wdata),
        .restart_req     (restart_req),
        .vector_ack      (vector_ack),
        .always_on_fuse  (fuse),
        .pin_rst_in      (src[0]),
        .brownout_rst_in (src[1]),
        .scan_rst_in     (src[2]),
        .rdata           (rdata),
        .guard_reset     (guard_reset),
        .timeout_irq     (timeout_irq)
    );

    // ----------------------------------------------------------------
    // Clocks and run limit
    // ----------------------------------------------------------------
    // System clock of 20 ns; the oscillator is sped up to ten system cycles per
    // period so that periods stay short, and it stands still when not needed.
    always #10 clk = ~clk;
    always #100 if (osc_run) osc_in = ~osc_in;

    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    // Inputs change at the falling edge, so the rising edge sees them settled.
    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_sel = io;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic io, input logic [7:0] a);
        @(negedge clk);
        io_sel = io;
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        rv = rdata;
    endtask : rd

    // Pulses restart_req (sel 0) or vector_ack (sel 1) for one cycle.
    task automatic pulse(input bit sel);
        @(negedge clk);
        if (sel) vector_ack = 1'b1;
        else restart_req = 1'b1;
        @(negedge clk);
        vector_ack = 1'b0;
        restart_req = 1'b0;
    endtask : pulse

    // Waits a bounded time for guard_reset (sel 1) or timeout_irq (sel 0).
    task automatic wait_hi(input bit sel, output int n);
        n = 0;
        while (((sel ? guard_reset : timeout_irq) !== 1'b1) && n < 3000) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask : wait_hi

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask : chk

    task automatic in_range(input int n, input int lo, input int hi);
        chk({7'h0, (n >= lo && n <= hi)}, 8'h01);
    endtask : in_range

    task automatic done_test(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask : done_test

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        int         n;
        logic [7:0] e;
        int         pos [3];
        clk = 1'b0;
        nrst = 1'b0;
        clk_en = 1'b1;
        osc_in = 1'b0;
        osc_run = 1'b0;
        io_sel = 1'b0;
        addr = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
        restart_req = 1'b0;
        vector_ack = 1'b0;
        fuse = 1'b0;
        src = 3'h0;
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        pos = '{1, 2, 4};
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        // Flags after power-on, both address spaces, refused places.
        rd(1'b0, 8'h54);
        chk(rv, 8'h01);
        rd(1'b1, 8'h34);
        chk(rv, 8'h01);
        rd(1'b1, 8'h60);
        chk(rv, 8'h00);
        wr(1'b0, 8'h10, 8'hFF);
        rd(1'b0, 8'h10);
        chk(rv, 8'h00);
        e = 8'h01;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            src[i] = 1'b1;
            repeat (4) @(negedge clk);
            src[i] = 1'b0;
            repeat (4) @(negedge clk);
            e = e | (8'h01 << pos[i]);
            rd(1'b0, 8'h54);
            chk(rv, e);
        end
        wr(1'b0, 8'h54, 8'h16);
        rd(1'b0, 8'h54);
        chk(rv, 8'h16);
        wr(1'b1, 8'h34, 8'h00);
        rd(1'b0, 8'h54);
        chk(rv, 8'h00);
        done_test("flags");
        // Interrupt mode: expiry, flag, clear by writing one.
        wr(1'b0, 8'h60, 8'h40);
        pulse(1'b0);
        osc_run = 1'b1;
        wait_hi(1'b0, n);
        in_range(n, (BASE - 1) * 10 - 2, BASE * 10 + 10);
        rd(1'b0, 8'h60);
        chk(rv, 8'hC0);
        pulse(1'b0);
        wr(1'b0, 8'h60, 8'hC0);
        rd(1'b0, 8'h60);
        chk(rv, 8'h40);
        chk({7'h0, timeout_irq}, 8'h00);
        e = 8'h00;
        repeat (15) begin
            pulse(1'b0);
            repeat (20) begin
                @(negedge clk);
                e[0] = e[0] | timeout_irq;
            end
        end
        chk(e, 8'h00);
        done_test("interrupt");
        // Period codes through the timed unlock sequence.
        for (int c = 0; c < 4; c++) begin
            pulse(1'b0);
            wr(1'b0, 8'h60, 8'h58);
            wr(1'b0, 8'h60, 8'h40 | 8'(c));
            repeat (4) @(negedge clk);
            rd(1'b0, 8'h60);
            chk(rv, 8'h40 | 8'(c));
            pulse(1'b0);
            wait_hi(1'b0, n);
            in_range(n, ((BASE << c) - 1) * 10 - 2, (BASE << c) * 10 + 10);
            pulse(1'b0);
            wr(1'b0, 8'h60, 8'hC0 | 8'(c));
        end
        done_test("period");
        // Change enable clears itself; locked writes cannot clear enable.
        pulse(1'b0);
        wr(1'b0, 8'h60, 8'h58);
        rd(1'b0, 8'h60);
        chk(rv & 8'h18, 8'h18);
        repeat (2) @(negedge clk);
        rd(1'b0, 8'h60);
        chk(rv & 8'h18, 8'h08);
        wr(1'b0, 8'h60, 8'h40);
        rd(1'b0, 8'h60);
        chk(rv & 8'h48, 8'h48);
        done_test("lock");
        // Combined mode: interrupt, vector, then system reset.
        wr(1'b0, 8'h60, 8'h58);
        wr(1'b0, 8'h60, 8'h48);
        pulse(1'b0);
        wait_hi(1'b0, n);
        in_range(n, 0, 2999);
        pulse(1'b1);
        rd(1'b0, 8'h60);
        chk(rv & 8'hC8, 8'h08);
        wait_hi(1'b1, n);
        in_range(n, 0, 2999);
        @(negedge clk);
        chk({7'h0, guard_reset}, 8'h00);
        osc_run = 1'b0;
        rd(1'b0, 8'h54);
        chk(rv, 8'h08);
        rd(1'b0, 8'h60);
        chk(rv, 8'h08);
        wr(1'b0, 8'h60, 8'h18);
        wr(1'b0, 8'h60, 8'h00);
        rd(1'b0, 8'h60);
        chk(rv & 8'h08, 8'h08);
        wr(1'b0, 8'h54, 8'h00);
        wr(1'b0, 8'h60, 8'h18);
        wr(1'b0, 8'h60, 8'h00);
        repeat (4) @(negedge clk);
        rd(1'b0, 8'h60);
        chk(rv, 8'h00);
        done_test("combined");
        // Stopped mode: with both enables clear, expiry does nothing.
        osc_run = 1'b1;
        e = 8'h00;
        repeat (80) begin
            @(negedge clk);
            e[0] = e[0] | guard_reset | timeout_irq;
        end
        chk(e, 8'h00);
        done_test("stopped");
        // Always-on fuse forces reset mode.
        fuse = 1'b1;
        repeat (4) @(negedge clk);
        wr(1'b0, 8'h60, 8'h40);
        rd(1'b0, 8'h60);
        chk(rv & 8'h48, 8'h08);
        osc_run = 1'b1;
        pulse(1'b0);
        wait_hi(1'b1, n);
        in_range(n, 0, 2999);
        done_test("fuse");
        final_report();
    end

endmodule : guard_timer_tb

`default_nettype wire
